// >>> hdl/mmsi_top.sv
/*
 * Memory map block: core address translation with segment, partition and
 * execute checks, DMA physical address check, and the APB register bank.
 * Assumes core and DMA requests come from logic on MCLK; APB master on MCLK.
 */
// The register addresses and the APB interface to the registers were left to the implementer.
`default_nettype none

module mmsi_top
	import mmsi_pkg::*;
(
	input  wire logic        MCLK,          // system clock, 40 MHz
	input  wire logic        RST,           // synchronous reset, high
	input  wire logic        PSEL,          // apb select
	input  wire logic        PENABLE,       // apb access phase
	input  wire logic        PWRITE,        // apb direction
	input  wire logic [7:0]  PADDR,         // apb byte address
	input  wire logic [31:0] PWDATA,        // apb write data
	input  wire logic [3:0]  PSTRB,         // apb byte strobes
	output logic             PREADY,        // apb ready
	output logic [31:0]      PRDATA,        // apb read data
	output logic             PSLVERR,       // apb error
	input  wire logic        CPU_REQ,       // core access request
	input  wire logic [31:0] CPU_VADDR,     // core virtual address
	input  wire logic        CPU_USER,      // core in user mode
	input  wire logic        CPU_FETCH,     // access is an instruction fetch
	output logic             CPU_ACK,       // translation result valid
	output logic [31:0]      CPU_PADDR,     // translated physical address
	output logic [1:0]       CPU_SEG,       // decoded segment
	output logic             CPU_CACHEABLE, // access may be cached
	output logic             CPU_FAULT,     // access refused
	input  wire logic        DMA_REQ,       // bus master request
	input  wire logic [31:0] DMA_ADDR,      // bus master physical address
	output logic             DMA_ACK,       // check result valid
	output logic [31:0]      DMA_PADDR,     // physical address passed on
	output logic             DMA_FAULT      // address not mapped
);
	import mmsi_pkg::*;

	// ****************************************************************
	// core and dma path decode
	// ****************************************************************
	mmsi_seg_e   c_seg;
	mmsi_rgn_e   c_rgn;
	mmsi_rgn_e   d_rgn;
	logic [31:0] c_paddr;
	logic [31:0] c_off;
	logic        c_cache;

	mmsi_xlate u_xlate (
		.vaddr     (CPU_VADDR),
		.seg       (c_seg),
		.paddr     (c_paddr),
		.cacheable (c_cache)
	);

	mmsi_region u_rgn_cpu (
		.paddr  (c_paddr),
		.rgn    (c_rgn),
		.offset (c_off)
	);

	mmsi_region u_rgn_dma (
		.paddr  (DMA_ADDR),
		.rgn    (d_rgn),
		.offset ()
	);

	// ****************************************************************
	// register state
	// ****************************************************************
	logic [31:0]   ctrl_r, ctrl_nxt;
	logic [31:0]   ram_ubase_r, ram_ubase_nxt;
	logic [31:0]   pfm_ubase_r, pfm_ubase_nxt;
	logic [ST_W-1:0] status_r, status_nxt;
	logic [31:0]   err_addr_r, err_addr_nxt;
	logic          pready_r, pready_nxt;
	logic [31:0]   prdata_r, prdata_nxt;
	logic          pslverr_r, pslverr_nxt;

	// ****************************************************************
	// fault checks
	// ****************************************************************
	logic seg_flt, part_flt, exec_flt, map_flt, c_flt;
	// faults only flag the access; raising the exception is left to the core

	always_comb begin
		seg_flt  = (c_seg == SEG_NONE) || (CPU_USER && c_seg != SEG_USER); // see [RULE3]
		map_flt  = (c_rgn == RGN_NONE); // see [RULE1]
		part_flt = 1'b0;
		if (CPU_USER) begin
			unique case (c_rgn)
				RGN_RAM:  part_flt = (c_off < ram_ubase_r); // see [RULE5]
				RGN_PFM:  part_flt = (c_off < pfm_ubase_r); // see [RULE5]
				RGN_SFR,
				RGN_BOOT,
				RGN_CFG:  part_flt = 1'b1;
				RGN_NONE: part_flt = 1'b0;
			endcase
		end
		// data ram runs code only when software allows it
		exec_flt = CPU_FETCH && ((c_rgn == RGN_RAM && !ctrl_r[CTRL_RAM_EXEC])
			|| c_rgn == RGN_SFR || c_rgn == RGN_CFG); // see [RULE5]
		c_flt    = seg_flt || map_flt || part_flt || exec_flt;
	end

	// ****************************************************************
	// apb slave
	// ****************************************************************
	logic apb_setup, apb_wr, map_hit, ro_hit;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	// zero wait states: ready is just the registered setup cycle, no counter needed
	always_comb begin
		apb_setup = PSEL && !PENABLE;
		apb_wr    = PSEL && PENABLE && pready_r && PWRITE && !pslverr_r;
		ro_hit    = (PADDR == OFS_PFM_SIZE) || (PADDR == OFS_BOOT_SIZE);
		map_hit   = ro_hit || PADDR == OFS_CTRL || PADDR == OFS_RAM_UBASE
			|| PADDR == OFS_PFM_UBASE || PADDR == OFS_STATUS || PADDR == OFS_ERR_ADDR;
		pready_nxt  = apb_setup;
		pslverr_nxt = apb_setup && !map_hit;
		prdata_nxt  = 32'h0000_0000;
		if (apb_setup && !PWRITE) begin
			unique case (PADDR)
				OFS_CTRL:      prdata_nxt = ctrl_r;
				OFS_RAM_UBASE: prdata_nxt = ram_ubase_r;
				OFS_PFM_UBASE: prdata_nxt = pfm_ubase_r;
				OFS_STATUS:    prdata_nxt = {{(32-ST_W){1'b0}}, status_r};
				OFS_ERR_ADDR:  prdata_nxt = err_addr_r;
				OFS_PFM_SIZE:  prdata_nxt = PFM_SIZE_VAL; // see [RULE8]
				OFS_BOOT_SIZE: prdata_nxt = BOOT_SIZE_VAL; // see [RULE9]
				default:       prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// register writes and sticky status
	// ****************************************************************
	logic [ST_W-1:0] st_set, st_clr;

	always_comb begin
		ctrl_nxt      = ctrl_r;
		ram_ubase_nxt = ram_ubase_r;
		pfm_ubase_nxt = pfm_ubase_r;
		err_addr_nxt  = err_addr_r;
		st_clr        = '0;
		// size registers have no write path at all
		if (apb_wr) begin // see [RULE10]
			unique case (PADDR)
				OFS_CTRL:      ctrl_nxt = merge(ctrl_r, PWDATA, PSTRB) & 32'h0000_0001;
				OFS_RAM_UBASE: ram_ubase_nxt = merge(ram_ubase_r, PWDATA, PSTRB); // see [RULE2]
				OFS_PFM_UBASE: pfm_ubase_nxt = merge(pfm_ubase_r, PWDATA, PSTRB); // see [RULE2]
				OFS_STATUS:    st_clr = PWDATA[ST_W-1:0] & {ST_W{PSTRB[0]}};
				default:       ctrl_nxt = ctrl_r;
			endcase
		end
		st_set = '0;
		if (CPU_REQ) begin
			st_set[ST_SEG_FAULT]  = seg_flt;
			st_set[ST_PART_FAULT] = part_flt;
			st_set[ST_EXEC_FAULT] = exec_flt;
			st_set[ST_MAP_FAULT]  = map_flt;
			if (c_flt) begin
				err_addr_nxt = CPU_VADDR;
			end
		end
		st_set[ST_DMA_FAULT] = DMA_REQ && d_rgn == RGN_NONE;
		// a fault in the clearing cycle stays visible
		status_nxt = (status_r & ~st_clr) | st_set;
	end

	// ****************************************************************
	// result registers
	// ****************************************************************
	logic        c_ack_nxt, d_ack_nxt, d_flt_nxt;
	// paddr follows vaddr every cycle; only ack and fault are qualified by the request

	always_comb begin
		c_ack_nxt = CPU_REQ;
		d_ack_nxt = DMA_REQ;
		d_flt_nxt = DMA_REQ && d_rgn == RGN_NONE; // see [RULE7]
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ctrl_r        <= CTRL_RST;
			ram_ubase_r   <= RAM_SIZE_VAL;
			pfm_ubase_r   <= PFM_SIZE_VAL;
			status_r      <= '0;
			err_addr_r    <= 32'h0000_0000;
			pready_r      <= 1'b0;
			prdata_r      <= 32'h0000_0000;
			pslverr_r     <= 1'b0;
			CPU_ACK       <= 1'b0;
			CPU_PADDR     <= 32'h0000_0000;
			CPU_SEG       <= 2'h0;
			CPU_CACHEABLE <= 1'b0;
			CPU_FAULT     <= 1'b0;
			DMA_ACK       <= 1'b0;
			DMA_PADDR     <= 32'h0000_0000;
			DMA_FAULT     <= 1'b0;
		end else begin
			ctrl_r        <= ctrl_nxt;
			ram_ubase_r   <= ram_ubase_nxt;
			pfm_ubase_r   <= pfm_ubase_nxt;
			status_r      <= status_nxt;
			err_addr_r    <= err_addr_nxt;
			pready_r      <= pready_nxt;
			prdata_r      <= prdata_nxt;
			pslverr_r     <= pslverr_nxt;
			CPU_ACK       <= c_ack_nxt;
			CPU_PADDR     <= c_paddr; // see [RULE6]
			CPU_SEG       <= c_seg;
			CPU_CACHEABLE <= c_cache; // see [RULE4]
			CPU_FAULT     <= CPU_REQ && c_flt;
			DMA_ACK       <= d_ack_nxt;
			DMA_PADDR     <= DMA_ADDR; // see [RULE7]
			DMA_FAULT     <= d_flt_nxt;
		end
	end

	always_comb begin
		PREADY  = pready_r;
		PRDATA  = prdata_r;
		PSLVERR = pslverr_r;
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);

	logic [95:0] cfg_all;
	assign cfg_all = {ctrl_r, ram_ubase_r, pfm_ubase_r};

	map_unique_a: assert property (CPU_REQ && c_rgn == RGN_NONE |=> CPU_ACK && CPU_FAULT) // see [RULE1]
		else $error("unmapped physical address not refused");
	word_write_a: assert property (PSEL && !PENABLE && PWRITE && PADDR == OFS_RAM_UBASE
		&& PSTRB == 4'hF ##1 PENABLE |=> ram_ubase_r == $past(PWDATA, 2)) // see [RULE2]
		else $error("full word write not stored");
	user_kernel_a: assert property (CPU_REQ && CPU_USER && CPU_VADDR[31]
		|=> CPU_FAULT && CPU_SEG != SEG_USER) // see [RULE3]
		else $error("user access to kernel segment not refused");
	cache_seg_a: assert property (CPU_REQ && CPU_VADDR[31:30] == 2'b10
		|=> CPU_CACHEABLE == !$past(CPU_VADDR[29])) // see [RULE4]
		else $error("kernel segment cache attribute wrong");
	ram_exec_a: assert property (CPU_REQ && CPU_FETCH && c_rgn == RGN_RAM
		&& !ctrl_r[CTRL_RAM_EXEC] |=> CPU_FAULT && status_r[ST_EXEC_FAULT]) // see [RULE5]
		else $error("fetch from non-executable ram not refused");
	xlate_addr_a: assert property (CPU_REQ |=> CPU_ACK
		&& CPU_PADDR == ($past(CPU_VADDR) & PHYS_MASK)) // see [RULE6]
		else $error("physical address does not match virtual address");
	dma_phys_a: assert property (DMA_REQ |=> DMA_ACK && DMA_PADDR == $past(DMA_ADDR)) // see [RULE7]
		else $error("dma address altered");
	pfm_size_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == OFS_PFM_SIZE
		|=> PREADY && !PSLVERR && PRDATA == PFM_SIZE_VAL) // see [RULE8]
		else $error("program flash size wrong");
	boot_size_a: assert property (PSEL && !PENABLE && !PWRITE && PADDR == OFS_BOOT_SIZE
		|=> PREADY && PRDATA == BOOT_SIZE_VAL) // see [RULE9]
		else $error("boot flash size wrong");
	ro_ignore_a: assert property (PSEL && !PENABLE && PWRITE && ro_hit
		|=> !PSLVERR ##1 cfg_all == $past(cfg_all, 2)) // see [RULE10]
		else $error("write to size register had an effect");

	// positive checks, so a fault line stuck high cannot pass unnoticed
	dma_pass_a: assert property (DMA_REQ && d_rgn != RGN_NONE // see [RULE1]
		|=> DMA_ACK && !DMA_FAULT)
		else $error("mapped bus master address refused");
	user_part_a: assert property (CPU_REQ && CPU_USER && !CPU_VADDR[31] && !CPU_FETCH // see [RULE5]
		&& c_rgn == RGN_RAM && c_off >= ram_ubase_r |=> !CPU_FAULT)
		else $error("user access above the partition refused");
	kernel_data_a: assert property (CPU_REQ && !CPU_USER && !CPU_FETCH // see [RULE3]
		&& c_seg != SEG_NONE && c_rgn != RGN_NONE |=> !CPU_FAULT)
		else $error("kernel data access to a mapped address refused");
	user_seg_a: assert property (CPU_REQ && !CPU_VADDR[31] // see [RULE3]
		|=> CPU_SEG == SEG_USER && CPU_PADDR[31:29] == 3'b000)
		else $error("user segment decode wrong");
	ro_quiet_a: assert property (PSEL && PENABLE && PREADY && PWRITE && ro_hit // see [RULE10]
		&& !CPU_REQ && !DMA_REQ |=> status_r == $past(status_r))
		else $error("write to size register touched the status");

	exec_ok_c: cover property (CPU_REQ && CPU_FETCH && c_rgn == RGN_RAM ##1 !CPU_FAULT);
	user_part_c: cover property (CPU_REQ && CPU_USER && part_flt ##1 CPU_FAULT);
	boot_read_c: cover property (PSEL && PENABLE && !PWRITE && PADDR == OFS_BOOT_SIZE);
	dma_fault_c: cover property (DMA_FAULT);
	cfg_dma_c: cover property (DMA_REQ && d_rgn == RGN_CFG ##1 !DMA_FAULT);

endmodule : mmsi_top

`default_nettype wire

// >>> hdl/mmsi_pkg.sv
/*
 * Constants, types and register map of the memory map and size block.
 * Assumes a single clock domain and an APB register port with 32-bit data.
 */
// What this block does
// [RULE1] Code, data, special registers and config words each sit at a unique spot in one 4 GB space.
// [RULE2] Every access in that space is 32 bits wide natively.
// [RULE3] User and kernel modes get separate spaces, and the kernel space has two segments.
// [RULE4] The first kernel segment is cacheable and the second one is not.
// [RULE5] Code and data memory may be split into user and kernel parts, and data memory may be executable.
// [RULE6] The core issues only virtual addresses, which are translated to physical ones.
// [RULE7] Bus masters such as DMA present physical addresses on their own.
// [RULE8] The program flash size register reads a fixed byte count (64, 128, 256 or 512 KB codes).
// [RULE9] The boot flash size register reads the fixed byte count of 12 KB.
// [RULE10] Writes to either size register are ignored and cause nothing else.
`default_nettype none

package mmsi_pkg;

	// ****************************************************************
	// register map, byte addresses
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_RAM_UBASE = 8'h04;
	localparam logic [7:0] OFS_PFM_UBASE = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_ERR_ADDR  = 8'h10;
	localparam logic [7:0] OFS_PFM_SIZE  = 8'h14;
	localparam logic [7:0] OFS_BOOT_SIZE = 8'h18;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int CTRL_RAM_EXEC   = 0;
	localparam int ST_SEG_FAULT    = 0;
	localparam int ST_PART_FAULT   = 1;
	localparam int ST_EXEC_FAULT   = 2;
	localparam int ST_MAP_FAULT    = 3;
	localparam int ST_DMA_FAULT    = 4;
	localparam int ST_W            = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// ****************************************************************
	// size codes
	// ****************************************************************
	localparam logic [31:0] PFM_SIZE_64K  = 32'h0001_0000;
	localparam logic [31:0] PFM_SIZE_128K = 32'h0002_0000;
	localparam logic [31:0] PFM_SIZE_256K = 32'h0004_0000;
	localparam logic [31:0] PFM_SIZE_512K = 32'h0008_0000;
	localparam logic [31:0] PFM_SIZE_VAL  = PFM_SIZE_512K;
	localparam logic [31:0] BOOT_SIZE_VAL = 32'h0000_3000;
	localparam logic [31:0] RAM_SIZE_VAL  = 32'h0002_0000;
	localparam logic [31:0] SFR_SIZE_VAL  = 32'h0010_0000;
	localparam logic [31:0] CFG_SIZE_VAL  = 32'h0000_0010;

	// ****************************************************************
	// physical layout and segment decode
	// ****************************************************************
	localparam logic [31:0] PHYS_MASK = 32'h1FFF_FFFF;
	localparam logic [31:0] RAM_BASE  = 32'h0000_0000;
	localparam logic [31:0] PFM_BASE  = 32'h1D00_0000;
	localparam logic [31:0] SFR_BASE  = 32'h1F80_0000;
	localparam logic [31:0] BOOT_BASE = 32'h1FC0_0000;
	localparam logic [31:0] CFG_BASE  = 32'h1FC0_2FF0;
	localparam logic [2:0]  SEG_TOP_KC = 3'b100;
	localparam logic [2:0]  SEG_TOP_KU = 3'b101;

	typedef enum logic [1:0] {
		SEG_USER     = 2'b00,
		SEG_KCACHE   = 2'b01,
		SEG_KUNCACHE = 2'b11,
		SEG_NONE     = 2'b10
	} mmsi_seg_e;

	typedef enum logic [2:0] {
		RGN_NONE = 3'b000,
		RGN_RAM  = 3'b001,
		RGN_PFM  = 3'b011,
		RGN_SFR  = 3'b010,
		RGN_BOOT = 3'b110,
		RGN_CFG  = 3'b111
	} mmsi_rgn_e;

endpackage : mmsi_pkg

`default_nettype wire

// >>> hdl/mmsi_xlate.sv
/*
 * Fixed virtual to physical translation and segment decode, combinational.
 * Assumes the caller registers the results.
 */
`default_nettype none

module mmsi_xlate
	import mmsi_pkg::*;
(
	input  wire logic [31:0] vaddr,     // virtual address from the core
	output mmsi_pkg::mmsi_seg_e seg,    // decoded segment
	output logic [31:0]      paddr,     // physical address
	output logic             cacheable  // access may be cached
);

	always_comb begin
		paddr = vaddr & PHYS_MASK; // see [RULE6]
		if (!vaddr[31]) begin
			seg       = SEG_USER; // see [RULE3]
			cacheable = 1'b1;
		end else if (vaddr[31:29] == SEG_TOP_KC) begin
			seg       = SEG_KCACHE; // see [RULE4]
			cacheable = 1'b1;
		end else if (vaddr[31:29] == SEG_TOP_KU) begin
			seg       = SEG_KUNCACHE; // see [RULE4]
			cacheable = 1'b0;
		end else begin
			// upper kernel range has no fixed mapping here
			seg       = SEG_NONE;
			cacheable = 1'b0;
		end
	end

endmodule : mmsi_xlate

`default_nettype wire

// >>> hdl/mmsi_region.sv
/*
 * Physical address region decode, combinational.
 * Assumes regions in the package do not overlap, except config inside boot.
 */
`default_nettype none

module mmsi_region
	import mmsi_pkg::*;
(
	input  wire logic [31:0] paddr,   // physical address
	output mmsi_pkg::mmsi_rgn_e rgn,  // region hit
	output logic [31:0]      offset   // offset inside that region
);

	always_comb begin
		rgn    = RGN_NONE; // see [RULE1]
		offset = 32'h0000_0000;
		if (paddr - RAM_BASE < RAM_SIZE_VAL) begin
			rgn    = RGN_RAM;
			offset = paddr - RAM_BASE;
		end else if (paddr - PFM_BASE < PFM_SIZE_VAL) begin
			rgn    = RGN_PFM;
			offset = paddr - PFM_BASE;
		end else if (paddr - SFR_BASE < SFR_SIZE_VAL) begin
			rgn    = RGN_SFR;
			offset = paddr - SFR_BASE;
		end else if (paddr - CFG_BASE < CFG_SIZE_VAL) begin
			// config words win over the boot flash around them
			rgn    = RGN_CFG;
			offset = paddr - CFG_BASE;
		end else if (paddr - BOOT_BASE < BOOT_SIZE_VAL) begin
			rgn    = RGN_BOOT;
			offset = paddr - BOOT_BASE;
		end
	end

endmodule : mmsi_region

`default_nettype wire

// >>> tb/mmsi_far_model.sv
/*
 * Far-side model: a core that issues virtual addresses and a bus master
 * that issues physical ones, each driven through a task of the bench.
 * Assumes the block answers one cycle after every request cycle.
 */
`default_nettype none

module mmsi_far_model (
	input  wire logic        mclk,      // system clock
	output logic             cpu_req,   // core request
	output logic [31:0]      cpu_vaddr, // core virtual address
	output logic             cpu_user,  // core in user mode
	output logic             cpu_fetch, // instruction fetch
	input  wire logic        cpu_ack,   // translation valid
	input  wire logic [31:0] cpu_paddr, // translated address
	input  wire logic [1:0]  cpu_seg,   // decoded segment
	input  wire logic        cpu_cache, // may be cached
	input  wire logic        cpu_fault, // access refused
	output logic             dma_req,   // bus master request
	output logic [31:0]      dma_addr,  // bus master address
	input  wire logic        dma_ack,   // check valid
	input  wire logic [31:0] dma_paddr, // address passed on
	input  wire logic        dma_fault  // address unmapped
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cpu_req   = 1'b0;
		cpu_vaddr = 32'h0;
		cpu_user  = 1'b0;
		cpu_fetch = 1'b0;
		dma_req   = 1'b0;
		dma_addr  = 32'h0;
	end

	// ********
	// requests
	// ********
	// idle address lines show the inverse of the last value and the request line drops to 0, so a stale sample never matches
	task automatic core_go(input logic [31:0] va, input logic u, input logic f,
		output logic ok, output logic [31:0] pa, output logic [1:0] sg,
		output logic ca, output logic fl);
		@(posedge mclk);
		cpu_req   <= 1'b1;
		cpu_vaddr <= va;
		cpu_user  <= u;
		cpu_fetch <= f;
		@(posedge mclk);
		cpu_req   <= 1'b0;
		cpu_vaddr <= ~va;
		cpu_user  <= ~u;
		cpu_fetch <= ~f;
		@(posedge mclk);
		ok = cpu_ack;
		pa = cpu_paddr;
		sg = cpu_seg;
		ca = cpu_cache;
		fl = cpu_fault;
	endtask : core_go

	task automatic core_two(input logic [31:0] a0, input logic [31:0] a1,
		output logic k0, output logic k1, output logic [31:0] p0, output logic [31:0] p1);
		@(posedge mclk);
		cpu_req   <= 1'b1;
		cpu_vaddr <= a0;
		cpu_user  <= 1'b0;
		cpu_fetch <= 1'b0;
		@(posedge mclk);
		cpu_vaddr <= a1;
		@(posedge mclk);
		cpu_req   <= 1'b0;
		cpu_vaddr <= ~a1;
		k0 = cpu_ack;
		p0 = cpu_paddr;
		@(posedge mclk);
		k1 = cpu_ack;
		p1 = cpu_paddr;
	endtask : core_two

	task automatic dma_go(input logic [31:0] a, output logic ok,
		output logic [31:0] pa, output logic fl);
		@(posedge mclk);
		dma_req  <= 1'b1;
		dma_addr <= a;
		@(posedge mclk);
		dma_req  <= 1'b0;
		dma_addr <= ~a;
		@(posedge mclk);
		ok = dma_ack;
		pa = dma_paddr;
		fl = dma_fault;
	endtask : dma_go

endmodule : mmsi_far_model

`default_nettype wire

// >>> tb/mmsi_tb_top.sv
/*
 * Self-checking bench of the memory map block: a row table of register,
 * core and bus master accesses, then strobe, back-to-back and reset cases.
 * Assumes core and bus master answers come one cycle after a request.
 */
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end

module mmsi_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import mmsi_pkg::*;

	logic        mclk = 1'b0, rst = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, cpu_vaddr, cpu_paddr, dma_addr, dma_paddr;
	logic [3:0]  pstrb = 4'h0;
	logic        pready, pslverr, cpu_req, cpu_user, cpu_fetch, cpu_ack, cpu_cache;
	logic        cpu_fault, dma_req, dma_ack, dma_fault;
	logic [1:0]  cpu_seg;
	int          n_fail = 0;
	int          n_tests = 0;

	typedef struct {
		logic [1:0]  k;  // 0 read, 1 write, 2 core, 3 bus master
		logic [31:0] a;
		logic [31:0] d;  // write data, or {fetch, user} for the core
		logic [31:0] e;  // read data or physical address
		logic [2:0]  cs; // {cacheable, segment}
		logic [1:0]  xm; // {check value, error or fault}
	} mmsi_row_s;
	mmsi_row_s rows[$];

	always #12.5 mclk = ~mclk;

	mmsi_top mmsi_top_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
		.PRDATA(prdata), .PSLVERR(pslverr), .CPU_REQ(cpu_req), .CPU_VADDR(cpu_vaddr),
		.CPU_USER(cpu_user), .CPU_FETCH(cpu_fetch), .CPU_ACK(cpu_ack),
		.CPU_PADDR(cpu_paddr), .CPU_SEG(cpu_seg), .CPU_CACHEABLE(cpu_cache),
		.CPU_FAULT(cpu_fault), .DMA_REQ(dma_req), .DMA_ADDR(dma_addr), .DMA_ACK(dma_ack),
		.DMA_PADDR(dma_paddr), .DMA_FAULT(dma_fault));

	mmsi_far_model mmsi_far_model_i (.mclk(mclk), .cpu_req(cpu_req),
		.cpu_vaddr(cpu_vaddr), .cpu_user(cpu_user), .cpu_fetch(cpu_fetch),
		.cpu_ack(cpu_ack), .cpu_paddr(cpu_paddr), .cpu_seg(cpu_seg),
		.cpu_cache(cpu_cache), .cpu_fault(cpu_fault), .dma_req(dma_req),
		.dma_addr(dma_addr), .dma_ack(dma_ack), .dma_paddr(dma_paddr),
		.dma_fault(dma_fault));

	// ********
	// tasks
	// ********
	task automatic stop_test();
		if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic add(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d,
		input logic [31:0] e, input logic [2:0] cs, input logic [1:0] xm);
		rows.push_back('{k, a, d, e, cs, xm});
	endtask : add

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic er);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	initial begin
		repeat (5000) @(posedge mclk);
		n_fail++;
		stop_test();
	end

	// ********
	// main sequence
	// ********
	initial begin
		mmsi_row_s   r;
		logic [31:0] v, pa, p0, p1;
		logic [1:0]  sg;
		logic        er, ok, ca, fl, k0, k1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		add(2'h0, 32'h14, 32'h0, PFM_SIZE_VAL, 3'h0, 2'h2);
		add(2'h0, 32'h18, 32'h0, 32'h00003000, 3'h0, 2'h2);
		add(2'h1, 32'h14, 32'hFFFFFFFF, 32'h0, 3'h0, 2'h0);
		add(2'h0, 32'h14, 32'h0, PFM_SIZE_VAL, 3'h0, 2'h2);
		add(2'h1, 32'h18, 32'h0, 32'h0, 3'h0, 2'h0);
		add(2'h0, 32'h18, 32'h0, 32'h00003000, 3'h0, 2'h2);
		add(2'h0, 32'h1C, 32'h0, 32'h0, 3'h0, 2'h1);
		add(2'h0, 32'h02, 32'h0, 32'h0, 3'h0, 2'h1);
		add(2'h1, 32'h20, 32'h1, 32'h0, 3'h0, 2'h1);
		add(2'h2, 32'h80000010, 32'h0, 32'h10, 3'h5, 2'h2);
		add(2'h2, 32'hA0000010, 32'h0, 32'h10, 3'h3, 2'h2);
		add(2'h2, 32'h80000100, 32'h2, 32'h100, 3'h5, 2'h3);
		add(2'h1, 32'h00, 32'h1, 32'h0, 3'h0, 2'h0);
		add(2'h2, 32'h80000100, 32'h2, 32'h100, 3'h5, 2'h2);
		add(2'h2, 32'hBF800000, 32'h2, 32'h1F800000, 3'h3, 2'h3);
		add(2'h2, 32'hBF800000, 32'h0, 32'h1F800000, 3'h3, 2'h2);
		add(2'h2, 32'h9FC02FF0, 32'h2, 32'h1FC02FF0, 3'h5, 2'h3);
		add(2'h2, 32'h80100000, 32'h0, 32'h00100000, 3'h5, 2'h3);
		add(2'h2, 32'hC0000000, 32'h0, 32'h0, 3'h0, 2'h1);
		add(2'h2, 32'h80000000, 32'h1, 32'h0, 3'h0, 2'h1);
		add(2'h2, 32'h00000000, 32'h1, 32'h0, 3'h4, 2'h3);
		add(2'h1, 32'h04, 32'h00010000, 32'h0, 3'h0, 2'h0);
		add(2'h1, 32'h08, 32'h00040000, 32'h0, 3'h0, 2'h0);
		add(2'h2, 32'h1D040000, 32'h1, 32'h1D040000, 3'h4, 2'h2);
		add(2'h2, 32'h1D000000, 32'h1, 32'h1D000000, 3'h4, 2'h3);
		add(2'h2, 32'h00010000, 32'h1, 32'h00010000, 3'h4, 2'h2);
		add(2'h2, 32'h1F800000, 32'h1, 32'h1F800000, 3'h4, 2'h3);
		add(2'h3, 32'h1D000000, 32'h0, 32'h1D000000, 3'h0, 2'h2);
		add(2'h3, 32'h00020000, 32'h0, 32'h00020000, 3'h0, 2'h3);
		add(2'h3, 32'h1FC02FF0, 32'h0, 32'h1FC02FF0, 3'h0, 2'h2);
		add(2'h0, 32'h10, 32'h0, 32'h1F800000, 3'h0, 2'h2);
		add(2'h0, 32'h0C, 32'h0, 32'h1F, 3'h0, 2'h2);
		foreach (rows[i]) begin
			r = rows[i];
			if (r.k < 2'h2) begin
				apb(r.k[0], r.a[7:0], r.d, 4'hF, v, er);
				`CHK("pslverr", r.xm[0], er)
				if (r.xm[1]) `CHK("prdata", r.e, v)
			end else begin
				if (r.k[0]) mmsi_far_model_i.dma_go(r.a, ok, pa, fl);
				else mmsi_far_model_i.core_go(r.a, r.d[0], r.d[1], ok, pa, sg, ca, fl);
				`CHK("ack", 1'b1, ok)
				`CHK("fault", r.xm[0], fl)
				if (r.xm[1]) `CHK("paddr", r.e, pa)
				if (r.xm[1] && !r.k[0]) `CHK("seg_cache", r.cs, {ca, sg})
			end
		end
		// a write without byte strobes must leave the sticky faults alone
		apb(1'b1, OFS_STATUS, 32'h1F, 4'h0, v, er);
		apb(1'b0, OFS_STATUS, 32'h0, 4'hF, v, er);
		`CHK("status_kept", 32'h1F, v)
		apb(1'b1, OFS_STATUS, 32'h1F, 4'hF, v, er);
		apb(1'b0, OFS_STATUS, 32'h0, 4'hF, v, er);
		`CHK("status_clear", 32'h0, v)
		mmsi_far_model_i.core_two(32'h80000020, 32'hA0000040, k0, k1, p0, p1);
		`CHK("ack_pair", 2'h3, {k0, k1})
		`CHK("paddr_pair", {32'h20, 32'h40}, {p0, p1})
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		`CHK("ack_reset", 3'h0, {cpu_ack, dma_ack, pready})
		apb(1'b0, OFS_CTRL, 32'h0, 4'hF, v, er);
		`CHK("ctrl_reset", 32'h0, v)
		apb(1'b0, OFS_RAM_UBASE, 32'h0, 4'hF, v, er);
		`CHK("ubase_reset", 32'h00020000, v)
		apb(1'b0, OFS_PFM_UBASE, 32'h0, 4'hF, v, er);
		`CHK("pfm_ubase_reset", 32'h00080000, v)
		apb(1'b0, OFS_BOOT_SIZE, 32'h0, 4'hF, v, er);
		`CHK("boot_after_reset", 32'h00003000, v)
		stop_test();
	end

endmodule : mmsi_tb_top

`default_nettype wire
